// file: sar_adc_pkg.sv
// shared constants and types for the converter control and readout block
package sar_adc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // result format
  localparam int RESULT_BITS = 14;
  localparam int IDX_W       = 4;
  localparam logic [IDX_W-1:0]       MSB_IDX    = 4'hD;
  localparam logic [RESULT_BITS-1:0] MSB_TRIAL  = 14'h2000;
  localparam logic [RESULT_BITS-1:0] RESULT_RST = 14'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // serial clock edge counter
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing; the cycle counts are all derived from the internal oscillator rate
  localparam int TICK_W           = 8;
  localparam int SYS_CLK_MHZ      = 200;
  localparam int SAMPLE_RATE_KSPS = 1000;
  localparam int THROUGHPUT_NS    = 1000000 / SAMPLE_RATE_KSPS;
  localparam int ACQ_TIME_NS      = 50;
  localparam int CONV_TIME_NS     = 700;
  localparam int CONV_CYCLES      = CONV_TIME_NS * SYS_CLK_MHZ / 1000;
  // a least time rounds up, a per-bit share rounds down
  localparam logic [TICK_W-1:0] ACQ_CYCLES =
    TICK_W'((ACQ_TIME_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [TICK_W-1:0] BIT_CYCLES =
    TICK_W'(CONV_CYCLES / RESULT_BITS);
  localparam logic [TICK_W-1:0] TICK_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // control states
  typedef enum logic [1:0] {
    S_SLEEP,
    S_ACQ,
    S_CONV,
    S_READY
  } state_t;

endpackage : sar_adc_pkg

// file: sck_link_if.sv
// carries the serial clock edge count from the link domain to the core
`timescale 1ns/10ps
interface sck_link_if;
  logic [sar_adc_pkg::CNT_W-1:0] edge_cnt_gray;

  modport counter (
    output edge_cnt_gray
  );

  modport reader (
    input  edge_cnt_gray
  );
endinterface : sck_link_if

// file: sck_edge_counter.sv
// gray coded count of rising serial clock edges within one frame
`timescale 1ns/10ps
module sck_edge_counter (
  input  wire logic   sck,
  input  wire logic   convert_start_n,
  input  wire logic   rst_n,
  sck_link_if.counter link
);

  typedef struct packed {
    logic [sar_adc_pkg::CNT_W-1:0] bin;
    logic [sar_adc_pkg::CNT_W-1:0] gray;
  } cnt_state_t;

  cnt_state_t st_ff;
  cnt_state_t nxt_st;
  logic       clr_n;

  ////////////////////////////////////////////////////////////////////////////
  // the frame's own select ends the count: sck may stand still outside it,
  // and the host holds sck low when select falls, so release is safe
  assign clr_n = rst_n & ~convert_start_n;

  // saturates so the gray code never wraps with a multi-bit change
  always_comb
  begin
    nxt_st = st_ff;
    if (st_ff.bin != sar_adc_pkg::CNT_MAX)
    begin
      nxt_st.bin = st_ff.bin + 6'h01; // see RQ10
    end
    nxt_st.gray = nxt_st.bin ^ (nxt_st.bin >> 1);
  end

  always_ff @(posedge sck or negedge clr_n)
  begin
    if (!clr_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign link.edge_cnt_gray = st_ff.gray;

endmodule : sck_edge_counter

// file: sar_adc_serial_readout.sv
// conversion control and serial result readout of a 14-bit sar converter
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RQ1: a falling edge on convert_start_n starts a new conversion.
// RQ2: conversion is paced by the internal clock, never by sck.
// RQ3: conversion circuitry powers down by itself once the result is done.
// RQ4: sdo driver is off while convert_start_n is high.
// RQ5: sdo is driven while convert_start_n low and power_down_n high.
// RQ6: power_down_n low puts the converter into power-down.
// RQ7: power_down_n low mid-conversion aborts it and releases sdo.
// RQ8: busy stays high for the whole conversion.
// RQ9: busy falls as soon as the conversion completes.
// RQ10: result shifts out on rising sck, msb first, lsb last.
// RQ11: fourteen result bits, then zeros while the host keeps clocking.
// RQ12: the host keeps sck low whenever it is not reading.
// RQ13: result is readable in the same cycle, no pipeline latency.
// RQ14: msb appears as busy falls; each rising sck advances one bit.
module sar_adc_serial_readout (
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  input  wire logic                               sck,
  input  wire logic                               convert_start_n,
  input  wire logic                               power_down_n,
  input  wire logic                               cmp_in,
  output logic                                    busy,
  output logic                                    sdo,
  output logic                                    sdo_oe,
  output logic [sar_adc_pkg::RESULT_BITS-1:0]     dac_code,
  output logic                                    hold,
  output logic                                    analog_en
);

  ////////////////////////////////////////////////////////////////////////////
  // state of the core domain
  typedef struct packed {
    logic                                cs_meta;
    logic                                cs_sync;
    logic                                cs_prev;
    logic                                pd_meta;
    logic                                pd_sync;
    logic [sar_adc_pkg::CNT_W-1:0]       cnt_meta;
    logic [sar_adc_pkg::CNT_W-1:0]       cnt_sync;
    sar_adc_pkg::state_t                 state;
    logic [sar_adc_pkg::IDX_W-1:0]       bit_idx;
    logic [sar_adc_pkg::TICK_W-1:0]      tick;
    logic [sar_adc_pkg::RESULT_BITS-1:0] trial;
    logic [sar_adc_pkg::RESULT_BITS-1:0] result;
    logic [sar_adc_pkg::CNT_W-1:0]       base;
    logic                                busy;
    logic                                sdo;
    logic                                sdo_oe;
    logic                                hold;
    logic                                analog_en;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    cs_meta:   1'b1,
    cs_sync:   1'b1,
    cs_prev:   1'b1,
    pd_meta:   1'b0,
    pd_sync:   1'b0,
    cnt_meta:  sar_adc_pkg::CNT_RST,
    cnt_sync:  sar_adc_pkg::CNT_RST,
    state:     sar_adc_pkg::S_SLEEP,
    bit_idx:   sar_adc_pkg::MSB_IDX,
    tick:      sar_adc_pkg::TICK_RST,
    trial:     sar_adc_pkg::RESULT_RST,
    result:    sar_adc_pkg::RESULT_RST,
    base:      sar_adc_pkg::CNT_RST,
    busy:      1'b0,
    sdo:       1'b0,
    sdo_oe:    1'b0,
    hold:      1'b0,
    analog_en: 1'b0
  };

  core_state_t st_ff;
  core_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // link side: counts sck edges on sck itself
  sck_link_if link ();

  sck_edge_counter u_edge_counter (
    .sck             (sck),
    .convert_start_n (convert_start_n),
    .rst_n           (rst_n),
    .link            (link.counter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [sar_adc_pkg::CNT_W-1:0] gray2bin(
    input logic [sar_adc_pkg::CNT_W-1:0] g
  );
    logic [sar_adc_pkg::CNT_W-1:0] b;
    b = '0;
    b[sar_adc_pkg::CNT_W-1] = g[sar_adc_pkg::CNT_W-1];
    for (int i = sar_adc_pkg::CNT_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  // bit of the result that belongs on sdo after idx rising edges
  function automatic logic result_bit(
    input logic [sar_adc_pkg::RESULT_BITS-1:0] word,
    input logic [sar_adc_pkg::CNT_W-1:0]       idx
  );
    logic [sar_adc_pkg::IDX_W-1:0] pos;
    pos = sar_adc_pkg::MSB_IDX - idx[sar_adc_pkg::IDX_W-1:0];
    if (idx < sar_adc_pkg::CNT_W'(sar_adc_pkg::RESULT_BITS))
    begin
      return word[pos]; // see RQ10
    end
    return 1'b0; // see RQ11
  endfunction : result_bit

  // keep the bit under trial, or drop it when the level overshot the input
  function automatic logic [sar_adc_pkg::RESULT_BITS-1:0] sar_decide(
    input logic [sar_adc_pkg::RESULT_BITS-1:0] trial,
    input logic [sar_adc_pkg::IDX_W-1:0]       pos,
    input logic                                cmp
  );
    logic [sar_adc_pkg::RESULT_BITS-1:0] word;
    word = trial;
    if (!cmp)
    begin
      word[pos] = 1'b0;
    end
    return word;
  endfunction : sar_decide

  // next trial level: bits decided so far plus the next lower bit set
  function automatic logic [sar_adc_pkg::RESULT_BITS-1:0] sar_next(
    input logic [sar_adc_pkg::RESULT_BITS-1:0] decided,
    input logic [sar_adc_pkg::IDX_W-1:0]       pos
  );
    logic [sar_adc_pkg::RESULT_BITS-1:0] word;
    word = decided;
    word[pos] = 1'b1;
    return word;
  endfunction : sar_next

  // what a stopped converter shows: idle, unpowered, sdo low
  function automatic core_state_t go_quiet(
    input core_state_t s
  );
    core_state_t q;
    q           = s;
    q.state     = sar_adc_pkg::S_SLEEP;
    q.busy      = 1'b0;
    q.analog_en = 1'b0;
    q.hold      = 1'b0;
    q.sdo       = 1'b0;
    return q;
  endfunction : go_quiet

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic                                cs_fall;
    logic [sar_adc_pkg::CNT_W-1:0]       cnt_bin;
    logic [sar_adc_pkg::CNT_W-1:0]       idx;
    logic [sar_adc_pkg::RESULT_BITS-1:0] decided;
    logic [sar_adc_pkg::IDX_W-1:0]       next_idx;

    cs_fall  = 1'b0;
    cnt_bin  = '0;
    idx      = '0;
    decided  = '0;
    next_idx = '0;
    nxt_st   = st_ff;

    // two-stage synchronisers for both control pins and the link count
    nxt_st.cs_meta  = convert_start_n;
    nxt_st.cs_sync  = st_ff.cs_meta;
    nxt_st.cs_prev  = st_ff.cs_sync;
    nxt_st.pd_meta  = power_down_n;
    nxt_st.pd_sync  = st_ff.pd_meta;
    nxt_st.cnt_meta = link.edge_cnt_gray;
    nxt_st.cnt_sync = st_ff.cnt_meta;

    cs_fall = st_ff.cs_prev & ~st_ff.cs_sync;
    cnt_bin = gray2bin(st_ff.cnt_sync);
    idx     = cnt_bin - st_ff.base;

    // driver follows select, gated by power-down
    nxt_st.sdo_oe = ~st_ff.cs_sync & st_ff.pd_sync; // see RQ4 see RQ5

    case (st_ff.state)
      sar_adc_pkg::S_SLEEP:
      begin
        nxt_st = go_quiet(nxt_st); // see RQ3
      end

      // sample is held; let the array settle before the first decision
      sar_adc_pkg::S_ACQ:
      begin
        nxt_st.tick = st_ff.tick + 8'h01; // see RQ2
        if (st_ff.tick == sar_adc_pkg::ACQ_CYCLES - 8'h01)
        begin
          nxt_st.tick  = sar_adc_pkg::TICK_RST;
          nxt_st.state = sar_adc_pkg::S_CONV;
        end
      end

      sar_adc_pkg::S_CONV:
      begin
        nxt_st.busy = 1'b1; // see RQ8
        nxt_st.tick = st_ff.tick + 8'h01; // see RQ2
        if (st_ff.tick == sar_adc_pkg::BIT_CYCLES - 8'h01)
        begin
          nxt_st.tick = sar_adc_pkg::TICK_RST;
          decided     = sar_decide(st_ff.trial, st_ff.bit_idx, cmp_in);
          if (st_ff.bit_idx == '0)
          begin
            nxt_st.result    = decided; // see RQ13
            nxt_st.trial     = decided;
            nxt_st.busy      = 1'b0; // see RQ9
            nxt_st.analog_en = 1'b0; // see RQ3
            nxt_st.hold      = 1'b0;
            nxt_st.base      = cnt_bin;
            // msb stands on sdo the same cycle busy falls
            nxt_st.sdo       = decided[sar_adc_pkg::MSB_IDX]; // see RQ14
            nxt_st.state     = sar_adc_pkg::S_READY;
          end
          else
          begin
            next_idx       = st_ff.bit_idx - 4'h1;
            nxt_st.trial   = sar_next(decided, next_idx);
            nxt_st.bit_idx = next_idx;
          end
        end
      end

      sar_adc_pkg::S_READY:
      begin
        // each synchronised sck edge moves the index on by one
        nxt_st.sdo = result_bit(st_ff.result, idx); // see RQ14
        if (st_ff.cs_sync)
        begin
          nxt_st.sdo   = 1'b0;
          nxt_st.state = sar_adc_pkg::S_SLEEP;
        end
      end

      default:
      begin
        nxt_st.state = sar_adc_pkg::S_SLEEP;
      end
    endcase

    // a new falling select restarts, even over an unread result
    if (cs_fall && st_ff.pd_sync)
    begin
      nxt_st.state     = sar_adc_pkg::S_ACQ; // see RQ1
      nxt_st.busy      = 1'b1; // see RQ8
      nxt_st.analog_en = 1'b1;
      nxt_st.hold      = 1'b1;
      nxt_st.tick      = sar_adc_pkg::TICK_RST;
      nxt_st.bit_idx   = sar_adc_pkg::MSB_IDX;
      nxt_st.trial     = sar_adc_pkg::MSB_TRIAL;
      nxt_st.sdo       = 1'b0;
    end

    // power-down wins over everything, including a start
    if (!st_ff.pd_sync)
    begin
      nxt_st         = go_quiet(nxt_st); // see RQ6 see RQ7
      // an aborted run leaves no half-counted slot behind
      nxt_st.tick    = sar_adc_pkg::TICK_RST;
      nxt_st.bit_idx = sar_adc_pkg::MSB_IDX;
      nxt_st.sdo_oe  = 1'b0; // see RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= CORE_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, straight from the state register
  assign busy      = st_ff.busy;
  assign sdo       = st_ff.sdo;
  assign sdo_oe    = st_ff.sdo_oe;
  assign dac_code  = st_ff.trial;
  assign hold      = st_ff.hold;
  assign analog_en = st_ff.analog_en;

endmodule : sar_adc_serial_readout

// file: readout_asserts.sv
// concurrent checks on the converter control and readout pins
`timescale 1ns/10ps
module readout_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        convert_start_n,
  input wire logic        power_down_n,
  input wire logic        busy,
  input wire logic        sdo,
  input wire logic        sdo_oe,
  input wire logic [13:0] dac_code,
  input wire logic        hold,
  input wire logic        analog_en
);
  logic [7:0] busy_len_ff;
  logic [7:0] nxt_busy_len;
  logic       cs_prev_ff;
  logic [1:0] start_dly_ff;

  //////////////////////////////////////////////////////////////////////////
  // busy run length, saturating so a stuck busy never wraps to 150
  always_comb
  begin
    nxt_busy_len = busy_len_ff + 8'h01;
    // a restart keeps busy high: count afresh as the new run begins
    if (!busy || start_dly_ff[1])
      nxt_busy_len = 8'h00;
    else if (busy_len_ff == 8'hFF)
      nxt_busy_len = 8'hFF;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_len_ff  <= 8'h00;
      cs_prev_ff   <= 1'b1;
      start_dly_ff <= 2'h0;
    end
    else
    begin
      busy_len_ff  <= nxt_busy_len;
      cs_prev_ff   <= convert_start_n;
      start_dly_ff <= {start_dly_ff[0], cs_prev_ff & ~convert_start_n};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  conv_length_a: assert property (
    $fell(busy) && power_down_n |-> busy_len_ff == 8'h96)
    else $error("busy run length wrong");
  start_busy_a: assert property (
    $fell(convert_start_n) && power_down_n && $past(power_down_n, 4)
    |-> ##[2:5] busy) else $error("start did not raise busy");
  cs_release_a: assert property (
    convert_start_n [*5] |-> !sdo_oe && !sdo)
    else $error("sdo driven while deselected");
  pd_abort_a: assert property (
    (!power_down_n) [*5] |-> !busy && !sdo_oe && !analog_en)
    else $error("power down did not stop conversion");
  select_drive_a: assert property (
    (!convert_start_n && power_down_n) [*6] |-> sdo_oe)
    else $error("sdo not driven while selected");
  msb_at_done_a: assert property (
    $fell(busy) && power_down_n && !convert_start_n
    |-> sdo_oe && sdo == dac_code[13]) else $error("msb not shown");
  power_off_a: assert property (
    $fell(busy) |-> !analog_en && !hold)
    else $error("converter left powered");
  busy_power_a: assert property (
    busy |-> analog_en && hold && !sdo)
    else $error("converter idle during busy");
endmodule : readout_checker

// file: host_model.sv
// host side model: convert start, power down and serial clock
`timescale 1ns/10ps
module host_model (
  output logic sck,
  output logic convert_start_n,
  output logic power_down_n
);
  initial
  begin
    sck = 1'b0;
    convert_start_n = 1'b1;
    power_down_n = 1'b1;
  end

  // one 160 ns period, 32 core clocks, so the odd offset keeps one phase against the core clock
  task automatic clock_one;
    #3.3 sck = 1'b1;
    #80 sck = 1'b0;
    #76.7;
  endtask : clock_one

  task automatic open_frame;
    convert_start_n = 1'b0;
  endtask : open_frame

  task automatic close_frame;
    convert_start_n = 1'b1;
  endtask : close_frame

  task automatic power_off;
    power_down_n = 1'b0;
  endtask : power_off

  task automatic power_on;
    power_down_n = 1'b1;
  endtask : power_on
endmodule : host_model

// file: sar_adc_serial_readout_tb.sv
// self-checking bench for the converter control and readout block
`timescale 1ns/10ps
module sar_adc_serial_readout_tb;
  logic        clk_sys;
  logic        rst_n;
  logic        sck;
  logic        cs_n;
  logic        pd_n;
  logic        busy;
  logic        sdo;
  logic        sdo_oe;
  logic        hold;
  logic        analog_en;
  logic [13:0] dac_code;
  logic [13:0] ain;
  int          err_total = 0;
  int          compares = 0;

  sar_adc_serial_readout DUT (.clk_sys(clk_sys), .rst_n(rst_n), .sck(sck),
    .convert_start_n(cs_n), .power_down_n(pd_n), .cmp_in(ain >= dac_code),
    .busy(busy), .sdo(sdo), .sdo_oe(sdo_oe), .dac_code(dac_code),
    .hold(hold), .analog_en(analog_en));
  host_model host (.sck(sck), .convert_start_n(cs_n), .power_down_n(pd_n));

  always #2.5 clk_sys = ~clk_sys;

  task automatic give_verdict;
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cycles

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 400)
    begin
      cycles(1);
      n++;
    end
    if (busy !== lvl)
    begin
      check({15'h0, lvl}, {15'h0, busy});
      give_verdict();
    end
  endtask : wait_busy

  task automatic scen_convert(input logic [13:0] v);
    ain = v;
    cycles(1);
    host.open_frame();
    wait_busy(1'b1);
    check(16'h0003, {14'h0, hold, analog_en});
    wait_busy(1'b0);
    check({2'h0, v}, {2'h0, dac_code});
    check(16'h0001, {15'h0, sdo_oe});
    check(16'h0000, {14'h0, hold, analog_en});
    check({15'h0, v[13]}, {15'h0, sdo});
    for (int i = 1; i < 16; i++)
    begin
      host.clock_one();
      check({15'h0, (i < 14) ? v[13 - i] : 1'b0}, {15'h0, sdo});
    end
    cycles(1);
    host.close_frame();
    cycles(6);
    check(16'h0, {14'h0, sdo_oe, sdo});
  endtask : scen_convert

  task automatic scen_abort;
    ain = 14'h1555;
    cycles(1);
    host.open_frame();
    wait_busy(1'b1);
    cycles(40);
    host.power_off();
    cycles(5);
    check(16'h0, {13'h0, busy, sdo_oe, analog_en});
    host.close_frame();
    cycles(3);
    host.open_frame();
    cycles(20);
    check(16'h0, {14'h0, busy, hold});
    host.close_frame();
    cycles(3);
    host.power_on();
    cycles(6);
    check(16'h0, {15'h0, busy});
  endtask : scen_abort

  // a second start mid-conversion restarts it; busy never drops between
  task automatic scen_restart;
    int n;
    n = 0;
    ain = 14'h0F0F;
    cycles(1);
    host.open_frame();
    wait_busy(1'b1);
    cycles(30);
    host.close_frame();
    cycles(3);
    ain = 14'h3A91;
    host.open_frame();
    while (busy === 1'b1 && n < 400)
    begin
      cycles(1);
      n++;
    end
    check(16'h0099, n[15:0]);
    check(16'h3A91, {2'h0, dac_code});
    host.close_frame();
    cycles(6);
  endtask : scen_restart

  initial
  begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    ain = 14'h0000;
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    cycles(6);
    scen_convert(14'h2A5C);
    scen_convert(14'h3FFF);
    scen_convert(14'h0000);
    scen_abort();
    scen_restart();
    scen_convert(14'h1D03);
    give_verdict();
  end
endmodule : sar_adc_serial_readout_tb

bind sar_adc_serial_readout readout_checker chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .convert_start_n(convert_start_n),
  .power_down_n(power_down_n), .busy(busy), .sdo(sdo), .sdo_oe(sdo_oe),
  .dac_code(dac_code), .hold(hold), .analog_en(analog_en));
